// ===== src/amc_device.sv
// accessory switch end: mode control, bus-low reset and interrupt pin
//
// Contract
// - both bus lines low 30 ms resets
// - after bus reset open paths, idle
// - supply sense falling edge resets everything
// - idle watches identity, attach selects mode
// - charger closes switch, drives charger_present_n low
// - usb cable selects usb paths, closes switch
// - dead battery floats irq, jig, serial, charger
// - car kit reported, protocol starts in uart
// - baseband mode bits drive car kit handshake
// - phone powered switch closes after wait
// - headset key presses reported via interrupt
// - audio type 2 starts uart, four patterns
// - audio type 2 any-to-any mode changes
// - pattern 100 enables data during audio
// - audio type 2 runs no car kit protocol
// - factory paths set at once with supply
// - factory jig low even without supply
// - interrupt is a falling edge on irq
// - after any reset mask set, irq low
// - mask cleared drives irq high
// - mask set holds irq high
// - masked events update status, irq after wait
`timescale 1ns/1ns
`default_nettype none
module amc_device
    import amc_pkg::*;
#(
    parameter int BUS_RESET_LEN = BUS_RESET_CYCLES
) (
    input  wire logic      CLK,
    input  wire logic      RST,
    amc_if.device          BUS,
    input  wire amc_acc_t  ACC_KIND,
    input  wire logic      KEY_PRESS,
    input  wire logic [4:0] KEY_CODE,
    input  wire logic      IO_SUPPLY_SENSE,
    input  wire logic      BATTERY_OK,
    input  wire logic      VBUS_VALID,
    input  wire logic      CK_ACK,
    output amc_path_t      PATH,
    output logic           VBUS_SWITCH_CLOSED,
    output logic           CHARGER_PRESENT_N_O,
    output logic           CHARGER_PRESENT_N_OE,
    output logic           JIG_N_O,
    output logic           JIG_N_OE,
    output logic           BOOT,
    output logic           DATA_DURING_AUDIO,
    output logic           CK_PROTOCOL_ACTIVE,
    output logic           CK_REQ,
    output logic [2:0]     CK_MODE
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic       supply_d;
    logic       scl_s;
    logic       sda_s;
    logic       io_s;
    logic       batt_s;
    logic       vbus_s;
    logic       ack_s;

    always_ff @(posedge CLK) begin
        sync1    <= {BUS.scl_i, BUS.sda_i, IO_SUPPLY_SENSE, BATTERY_OK, VBUS_VALID, CK_ACK};
        sync2    <= sync1;
        supply_d <= sync2[3];
    end
    assign {scl_s, sda_s, io_s, batt_s, vbus_s, ack_s} = sync2;

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    logic [BUS_CNT_W-1:0] bus_cnt;
    logic                 bus_fired;
    logic                 bus_rst;
    logic                 supply_fall;
    logic                 rst_all;

    // fires once per low stretch, so a stuck-low bus does not reset forever
    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_cnt   <= '0;
            bus_fired <= 1'b0;
        end else if (!scl_s && !sda_s) begin
            if (!bus_fired && bus_cnt == BUS_CNT_W'(BUS_RESET_LEN - 1)) begin
                bus_fired <= 1'b1;
            end else if (!bus_fired) begin
                bus_cnt <= bus_cnt + 1'b1;
            end
        end else begin
            bus_cnt   <= '0;
            bus_fired <= 1'b0;
        end
    end
    assign bus_rst     = (!scl_s && !sda_s) && !bus_fired
                         && bus_cnt == BUS_CNT_W'(BUS_RESET_LEN - 1);
    assign supply_fall = supply_d && !sync2[3];
    assign rst_all     = RST || bus_rst || supply_fall;

    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    amc_state_t state;
    amc_state_t next_state;
    logic       attach_ev;
    logic       detach_ev;
    logic       key_ev;

    always_comb begin
        next_state = state;
        case (state)
            ST_INIT: next_state = ST_IDLE;
            ST_IDLE: begin
                case (ACC_KIND)
                    ACC_USB:                            next_state = ST_USB;
                    ACC_USB_CHARGER, ACC_DED_CHARGER:   next_state = ST_CHARGER;
                    ACC_CARKIT:                         next_state = ST_CARKIT;
                    ACC_PPD:                            next_state = ST_PPD;
                    ACC_AUDIO1:                         next_state = ST_AUDIO1;
                    ACC_AUDIO2:                         next_state = ST_AUDIO2;
                    ACC_UART:                           next_state = ST_UART;
                    ACC_FACT_USB_OFF, ACC_FACT_USB_ON,
                    ACC_FACT_UART_OFF, ACC_FACT_UART_ON: next_state = ST_FACTORY;
                    default:                            next_state = ST_IDLE;
                endcase
            end
            default: begin
                if (ACC_KIND == ACC_NONE) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (rst_all) begin
            state <= ST_INIT;
        end else begin
            state <= next_state;
        end
    end

    assign attach_ev = state == ST_IDLE && ACC_KIND != ACC_NONE;
    assign detach_ev = state != ST_IDLE && state != ST_INIT && ACC_KIND == ACC_NONE;
    assign key_ev    = KEY_PRESS && (state == ST_AUDIO1 || state == ST_AUDIO2);

    // ------------------------------------------------------------
    // car kit and audio type 2 mode bits
    // ------------------------------------------------------------
    logic [2:0] ck_pend;
    logic       allowed;

    assign allowed = BUS.mode_val == MODE_USB || BUS.mode_val == MODE_UART
                     || BUS.mode_val == MODE_DDA || BUS.mode_val == MODE_AUDIO_ALT;

    always_ff @(posedge CLK) begin
        if (rst_all || attach_ev) begin
            CK_MODE <= MODE_UART;
            CK_REQ  <= 1'b0;
            ck_pend <= MODE_UART;
        end else if (state == ST_CARKIT) begin
            if (CK_REQ && ack_s) begin
                CK_MODE <= ck_pend;
                CK_REQ  <= 1'b0;
            end else if (BUS.mode_wr) begin
                ck_pend <= BUS.mode_val;
                CK_REQ  <= 1'b1;
            end
        end else if (state == ST_AUDIO2) begin
            // no handshake here, the switch follows the bits directly
            if (BUS.mode_wr && allowed) begin
                CK_MODE <= BUS.mode_val;
            end
        end else begin
            CK_REQ <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // phone powered switch wait
    // ------------------------------------------------------------
    logic [WAIT_CNT_W-1:0] ppd_cnt;
    logic                  ppd_done;

    always_ff @(posedge CLK) begin
        if (rst_all || state != ST_PPD) begin
            ppd_cnt  <= '0;
            ppd_done <= 1'b0;
        end else if (ppd_cnt == WAIT_CNT_W'(SWITCH_WAIT_CYCLES - 1)) begin
            ppd_done <= 1'b1;
        end else begin
            ppd_cnt <= ppd_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // switch and pin outputs
    // ------------------------------------------------------------
    amc_path_t next_path;
    amc_path_t mode_path;
    logic      next_vbus;
    logic      fact_usb;
    logic      fact_on;

    assign fact_usb = ACC_KIND == ACC_FACT_USB_OFF || ACC_KIND == ACC_FACT_USB_ON;
    assign fact_on  = ACC_KIND == ACC_FACT_USB_ON || ACC_KIND == ACC_FACT_UART_ON;

    always_comb begin
        case (CK_MODE)
            MODE_USB:                    mode_path = PATH_USB;
            MODE_UART:                   mode_path = PATH_UART;
            MODE_DDA:                    mode_path = PATH_DDA;
            MODE_MONO, MODE_STEREO,
            MODE_AUDIO_ALT:              mode_path = PATH_AUDIO;
            default:                     mode_path = PATH_OPEN;
        endcase
    end

    always_comb begin
        next_path = PATH_OPEN;
        next_vbus = 1'b0;
        case (state)
            ST_CHARGER: begin
                next_path = (ACC_KIND == ACC_USB_CHARGER) ? PATH_USB : PATH_OPEN;
                next_vbus = 1'b1;
            end
            ST_USB: begin
                next_path = PATH_USB;
                next_vbus = 1'b1;
            end
            ST_CARKIT: begin
                next_path = mode_path;
                next_vbus = vbus_s;
            end
            ST_AUDIO2: begin
                next_path = mode_path;
                next_vbus = 1'b1;
            end
            ST_PPD: begin
                next_path = PATH_AUDIO;
                next_vbus = ppd_done;
            end
            ST_AUDIO1: next_path = PATH_AUDIO;
            ST_UART: begin
                next_path = PATH_UART;
                next_vbus = vbus_s;
            end
            ST_FACTORY: begin
                // no wait timer and no read acknowledge in factory mode
                if (io_s) begin
                    next_path = fact_usb ? PATH_USB : PATH_UART;
                    next_vbus = fact_usb;
                end
            end
            default: next_path = PATH_OPEN;
        endcase
        if (!batt_s && next_path != PATH_USB) begin
            next_path = PATH_OPEN;
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_all) begin
            PATH                 <= PATH_OPEN;
            VBUS_SWITCH_CLOSED   <= 1'b0;
            CHARGER_PRESENT_N_OE <= 1'b0;
            JIG_N_OE             <= 1'b0;
            BOOT                 <= 1'b0;
            DATA_DURING_AUDIO    <= 1'b0;
            CK_PROTOCOL_ACTIVE   <= 1'b0;
        end else begin
            PATH                 <= next_path;
            VBUS_SWITCH_CLOSED   <= next_vbus;
            CHARGER_PRESENT_N_OE <= state == ST_CHARGER && batt_s;
            JIG_N_OE             <= state == ST_FACTORY && batt_s;
            BOOT                 <= state == ST_FACTORY && fact_on && batt_s;
            DATA_DURING_AUDIO    <= CK_MODE == MODE_DDA
                                    && (state == ST_CARKIT || state == ST_AUDIO2);
            CK_PROTOCOL_ACTIVE   <= state == ST_CARKIT;
        end
    end
    assign CHARGER_PRESENT_N_O = 1'b0;
    assign JIG_N_O             = 1'b0;

    // ------------------------------------------------------------
    // status and interrupt pin
    // ------------------------------------------------------------
    logic                  mask;
    logic                  irq_n;
    logic                  waiting;
    logic [WAIT_CNT_W-1:0] wait_cnt;
    logic                  pending;
    logic                  event_any;

    assign event_any = attach_ev || detach_ev || key_ev;
    assign pending   = BUS.ev_attach || BUS.ev_detach || BUS.ev_key;

    // set wins over the acknowledge, status updates even while masked
    always_ff @(posedge CLK) begin
        if (rst_all) begin
            BUS.ev_attach <= 1'b0;
            BUS.ev_detach <= 1'b0;
            BUS.ev_key    <= 1'b0;
            BUS.key_code  <= '0;
        end else begin
            BUS.ev_attach <= attach_ev || (BUS.ev_attach && !BUS.int_ack);
            BUS.ev_detach <= detach_ev || (BUS.ev_detach && !BUS.int_ack);
            BUS.ev_key    <= key_ev || (BUS.ev_key && !BUS.int_ack);
            if (key_ev) begin
                BUS.key_code <= KEY_CODE;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_all) begin
            mask     <= MASK_RST;
            irq_n    <= IRQ_N_RST;
            waiting  <= 1'b0;
            wait_cnt <= '0;
        end else if (BUS.mask_wr) begin
            mask     <= BUS.mask_val;
            irq_n    <= 1'b1;
            waiting  <= !BUS.mask_val && (pending || event_any);
            wait_cnt <= '0;
        end else if (!mask) begin
            if (waiting) begin
                if (wait_cnt == WAIT_CNT_W'(SWITCH_WAIT_CYCLES - 1)) begin
                    irq_n   <= 1'b0;
                    waiting <= 1'b0;
                end else begin
                    wait_cnt <= wait_cnt + 1'b1;
                end
            end else if (BUS.int_ack) begin
                irq_n <= 1'b1;
            end else if (irq_n && (event_any || pending)) begin
                irq_n <= 1'b0;
            end
        end
    end
    assign BUS.irq_o  = irq_n;
    assign BUS.irq_oe = batt_s;

endmodule : amc_device
`default_nettype wire

// ===== pkg/amc_pkg.sv
// shared constants and types for the accessory mode controller
package amc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ             = 50_000_000;
    localparam int BUS_RESET_MS       = 30;
    localparam int BUS_RESET_CYCLES   = BUS_RESET_MS * (CLK_HZ / 1000);
    localparam int BUS_CNT_W          = 21;
    localparam int SWITCH_WAIT_US     = 50;
    localparam int SWITCH_WAIT_CYCLES = SWITCH_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int WAIT_CNT_W         = 12;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic MASK_RST  = 1'b1;
    localparam logic IRQ_N_RST = 1'b0;

    // ------------------------------------------------------------
    // car kit / audio type 2 mode bits
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_USB       = 3'h0;
    localparam logic [2:0] MODE_UART      = 3'h1;
    localparam logic [2:0] MODE_MONO      = 3'h2;
    localparam logic [2:0] MODE_STEREO    = 3'h3;
    localparam logic [2:0] MODE_DDA       = 3'h4;
    localparam logic [2:0] MODE_AUDIO_ALT = 3'h5;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ACC_NONE          = 4'h0,
        ACC_USB           = 4'h1,
        ACC_USB_CHARGER   = 4'h2,
        ACC_DED_CHARGER   = 4'h3,
        ACC_CARKIT        = 4'h4,
        ACC_PPD           = 4'h5,
        ACC_AUDIO1        = 4'h6,
        ACC_AUDIO2        = 4'h7,
        ACC_UART          = 4'h8,
        ACC_FACT_USB_OFF  = 4'h9,
        ACC_FACT_USB_ON   = 4'ha,
        ACC_FACT_UART_OFF = 4'hb,
        ACC_FACT_UART_ON  = 4'hc
    } amc_acc_t;

    typedef enum logic [2:0] {
        PATH_OPEN  = 3'h0,
        PATH_USB   = 3'h1,
        PATH_UART  = 3'h2,
        PATH_AUDIO = 3'h3,
        PATH_DDA   = 3'h4
    } amc_path_t;

    typedef enum logic [9:0] {
        ST_INIT    = 10'h001,
        ST_IDLE    = 10'h002,
        ST_CHARGER = 10'h004,
        ST_USB     = 10'h008,
        ST_CARKIT  = 10'h010,
        ST_PPD     = 10'h020,
        ST_AUDIO1  = 10'h040,
        ST_AUDIO2  = 10'h080,
        ST_UART    = 10'h100,
        ST_FACTORY = 10'h200
    } amc_state_t;

endpackage : amc_pkg

// ===== pkg/amc_if.sv
// interface joining the baseband end and the accessory switch end
`timescale 1ns/1ns
`default_nettype none
interface amc_if;
    logic       scl_o;
    logic       scl_oe;
    logic       sda_o;
    logic       sda_oe;
    wire        scl_i;
    wire        sda_i;
    logic       irq_o;
    logic       irq_oe;
    wire        irq_i;
    logic       mask_wr;
    logic       mask_val;
    logic       mode_wr;
    logic [2:0] mode_val;
    logic       int_ack;
    logic       ev_attach;
    logic       ev_detach;
    logic       ev_key;
    logic [4:0] key_code;

    // pulled-up lines resolved from the enables
    assign scl_i = !(scl_oe && !scl_o);
    assign sda_i = !(sda_oe && !sda_o);
    assign irq_i = irq_oe ? irq_o : 1'b1;

    modport device (
        input  scl_i, sda_i, mask_wr, mask_val, mode_wr, mode_val, int_ack,
        output irq_o, irq_oe, ev_attach, ev_detach, ev_key, key_code
    );
    modport host (
        output scl_o, scl_oe, sda_o, sda_oe, mask_wr, mask_val, mode_wr, mode_val, int_ack,
        input  irq_i, ev_attach, ev_detach, ev_key, key_code
    );
endinterface : amc_if
`default_nettype wire

// ===== src/amc_host.sv
// baseband end: bus-low reset, interrupt edge detect, mask and mode writes
`timescale 1ns/1ns
`default_nettype none
module amc_host
    import amc_pkg::*;
#(
    parameter int BUS_RESET_LEN = BUS_RESET_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    amc_if.host             BUS,
    input  wire logic       REQ_BUS_RESET,
    input  wire logic       MASK_WRITE,
    input  wire logic       MASK_VALUE,
    input  wire logic       MODE_WRITE,
    input  wire logic [2:0] MODE_VALUE,
    input  wire logic       ACK,
    output logic            BUS_RESET_BUSY,
    output logic            IRQ_SEEN,
    output logic            IRQ_PENDING,
    output logic [7:0]      STATUS
);

    // ------------------------------------------------------------
    // bus-low reset generator
    // ------------------------------------------------------------
    logic [BUS_CNT_W-1:0] rst_cnt;

    always_ff @(posedge CLK) begin
        if (RST) begin
            BUS_RESET_BUSY <= 1'b0;
            rst_cnt        <= '0;
        end else if (BUS_RESET_BUSY) begin
            if (rst_cnt == BUS_CNT_W'(BUS_RESET_LEN - 1)) begin
                BUS_RESET_BUSY <= 1'b0;
            end else begin
                rst_cnt <= rst_cnt + 1'b1;
            end
        end else if (REQ_BUS_RESET) begin
            BUS_RESET_BUSY <= 1'b1;
            rst_cnt        <= '0;
        end
    end
    // lines are only pulled low, never driven high
    assign BUS.scl_o  = 1'b0;
    assign BUS.sda_o  = 1'b0;
    assign BUS.scl_oe = BUS_RESET_BUSY;
    assign BUS.sda_oe = BUS_RESET_BUSY;

    // ------------------------------------------------------------
    // control writes toward the switch
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            BUS.mask_wr  <= 1'b0;
            BUS.mask_val <= MASK_RST;
            BUS.mode_wr  <= 1'b0;
            BUS.mode_val <= MODE_UART;
            BUS.int_ack  <= 1'b0;
        end else begin
            BUS.mask_wr <= MASK_WRITE;
            BUS.mode_wr <= MODE_WRITE;
            BUS.int_ack <= ACK;
            if (MASK_WRITE) begin
                BUS.mask_val <= MASK_VALUE;
            end
            if (MODE_WRITE) begin
                BUS.mode_val <= MODE_VALUE;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt falling edge
    // ------------------------------------------------------------
    logic irq_s1;
    logic irq_s2;
    logic irq_d;

    always_ff @(posedge CLK) begin
        irq_s1 <= BUS.irq_i;
        irq_s2 <= irq_s1;
        irq_d  <= irq_s2;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ_SEEN    <= 1'b0;
            IRQ_PENDING <= 1'b0;
            STATUS      <= '0;
        end else begin
            IRQ_SEEN    <= irq_d && !irq_s2;
            IRQ_PENDING <= (irq_d && !irq_s2) || (IRQ_PENDING && !ACK);
            STATUS      <= {BUS.key_code, BUS.ev_key, BUS.ev_detach, BUS.ev_attach};
        end
    end

endmodule : amc_host
`default_nettype wire

// ===== dv/amc_checker.sv
// link checker for bus-low reset and interrupt pin
`timescale 1ns/1ns
`default_nettype none
module amc_checker #(parameter int BUS_RESET_LEN = 50) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic irq_o,
    input wire logic mask_wr,
    input wire logic mask_val,
    input wire logic ev_attach,
    input wire logic ev_detach,
    input wire logic ev_key
);
    // ----------
    // helpers
    // ----------
    localparam int WAIT_MIN = 2400; // a little under the switch wait
    int  low_cnt;
    int  wait_cnt;
    int  quiet;
    wire ev = ev_attach || ev_detach || ev_key;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    always_ff @(posedge CLK) begin
        low_cnt <= (scl_oe && !RST) ? low_cnt + 1 : 0;
    end
    // bus reset drops irq with no event, so excuse a few cycles after it
    always_ff @(posedge CLK) begin
        quiet <= RST ? 0 : scl_oe ? 8 : (quiet > 0 ? quiet - 1 : 0);
    end
    always_ff @(posedge CLK) begin
        if (RST || scl_oe || (mask_wr && mask_val)) wait_cnt <= 0;
        else if (mask_wr && ev) wait_cnt <= WAIT_MIN;
        else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    end
    AST_BUS_LOW_LEN: assert property ($fell(scl_oe) |-> low_cnt == BUS_RESET_LEN)
        else $error("bus low stretch length wrong");
    AST_LINES_TOGETHER: assert property (scl_oe == sda_oe)
        else $error("bus lines not low together");
    AST_BUS_RESET_CLEARS: assert property ($fell(scl_oe) |-> ##[1:6] (!irq_o && !ev))
        else $error("bus reset left irq or flags");
    AST_RESET_IRQ_LOW: assert property ($fell(RST) |-> !irq_o [*3])
        else $error("irq not low after reset");
    AST_MASK_CLEAR_HIGH: assert property (mask_wr && !mask_val |=> irq_o)
        else $error("irq not high after unmask");
    AST_MASK_SET_HOLD: assert property (mask_wr && mask_val |=> irq_o [*8])
        else $error("irq not held high when masked");
    AST_MASK_WAIT: assert property (wait_cnt > 0 |-> !$fell(irq_o))
        else $error("irq before switch wait ended");
    AST_IRQ_CAUSE: assert property ($fell(irq_o) && quiet == 0 |-> ev)
        else $error("irq edge without event");
    cover property ($fell(irq_o) && ev);
    cover property (wait_cnt == 1);
    cover property ($fell(scl_oe));
endmodule : amc_checker
`default_nettype wire

// ===== dv/accessory_mode_controller_tb_top.sv
// self-checking bench for the accessory mode controller link
`timescale 1ns/1ns
`default_nettype none
module accessory_mode_controller_tb_top;
    import amc_pkg::*;
    localparam int LEN = 50; // short bus-low count keeps the run brief
    logic       CLK = 1'b0;
    logic       RST = 1'b1;
    logic       key = 1'b0, sup = 1'b1, bat = 1'b1, ck_ack = 1'b0, breq = 1'b0;
    logic       mw = 1'b0, mv = 1'b0, dw = 1'b0, ack = 1'b0;
    logic [2:0] dv = 3'h0, ck_mode, m;
    logic [4:0] code = 5'h00;
    logic [7:0] stat;
    logic       vsw, chg, jig, boot, dda, ck_act, ck_req, busy, pend, seen;
    amc_acc_t   acc = ACC_NONE;
    amc_path_t  path;
    int         n_fail = 0, comparisons = 0, seed = 41, i, n_seen = 0, seen_mark = 0;
    amc_acc_t   kinds[8] = '{ACC_USB, ACC_USB_CHARGER, ACC_DED_CHARGER, ACC_CARKIT,
                             ACC_AUDIO2, ACC_FACT_UART_ON, ACC_UART, ACC_FACT_USB_OFF};
    logic [3:0] cfg[8] = '{4'h1, 4'h9, 4'h8, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1}; // {charger, path}
    logic [2:0] pat[5] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h2};
    always #10 CLK = ~CLK;
    always @(posedge CLK) ck_ack <= ck_req; // car kit answers, holds till request drops
    always @(posedge CLK) if (seen) n_seen <= n_seen + 1; // host edge pulses
    amc_if u_amc_if ();
    amc_device #(.BUS_RESET_LEN(LEN)) u_amc_device (
        .CLK(CLK), .RST(RST), .BUS(u_amc_if.device), .ACC_KIND(acc), .KEY_PRESS(key),
        .KEY_CODE(code), .IO_SUPPLY_SENSE(sup), .BATTERY_OK(bat), .VBUS_VALID(1'b1),
        .CK_ACK(ck_ack), .PATH(path), .VBUS_SWITCH_CLOSED(vsw), .CHARGER_PRESENT_N_O(),
        .CHARGER_PRESENT_N_OE(chg), .JIG_N_O(), .JIG_N_OE(jig), .BOOT(boot),
        .DATA_DURING_AUDIO(dda), .CK_PROTOCOL_ACTIVE(ck_act), .CK_REQ(ck_req),
        .CK_MODE(ck_mode));
    amc_host #(.BUS_RESET_LEN(LEN)) u_amc_host (
        .CLK(CLK), .RST(RST), .BUS(u_amc_if.host), .REQ_BUS_RESET(breq), .MASK_WRITE(mw),
        .MASK_VALUE(mv), .MODE_WRITE(dw), .MODE_VALUE(dv), .ACK(ack),
        .BUS_RESET_BUSY(busy), .IRQ_SEEN(seen), .IRQ_PENDING(pend), .STATUS(stat));
    amc_checker #(.BUS_RESET_LEN(LEN)) u_amc_checker (
        .CLK(CLK), .RST(RST), .scl_oe(u_amc_if.scl_oe), .sda_oe(u_amc_if.sda_oe),
        .irq_o(u_amc_if.irq_o), .mask_wr(u_amc_if.mask_wr), .mask_val(u_amc_if.mask_val),
        .ev_attach(u_amc_if.ev_attach), .ev_detach(u_amc_if.ev_detach),
        .ev_key(u_amc_if.ev_key));
    // ----------
    // tasks
    // ----------
    task automatic wrap_up;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask : tick
    // k: 0 mask, 1 mode, 2 ack
    task automatic wr(input int k, input logic [2:0] v);
        mw <= (k == 0);
        dw <= (k == 1);
        ack <= (k == 2);
        mv <= v[0];
        dv <= v;
        tick(1);
        {mw, dw, ack} <= 3'h0;
        tick(4);
    endtask : wr
    task automatic plug(input amc_acc_t k);
        acc <= k;
        tick(6);
    endtask : plug
    // key code only compared when the key flag is expected
    task automatic serve(input logic [7:0] e);
        for (i = 0; i < 4000 && pend !== 1'b1; i++) tick(1);
        if (pend !== 1'b1) begin
            n_fail++;
            wrap_up();
        end
        chk({stat[7:3] & {5{e[2]}}, stat[2:0]}, e);
        wr(2, 3'h0);
        chk(n_seen != seen_mark, 1'b1);
        seen_mark = n_seen;
    endtask : serve
    initial begin
        tick(10);
        RST <= 1'b0;
        tick(3);
        chk(u_amc_if.irq_o, 1'b0);
        chk(path, PATH_OPEN);
        wr(0, 3'h1);
        wr(0, 3'h0);
        for (int j = 0; j < 8; j++) begin
            plug(kinds[j]);
            chk({chg, path}, cfg[j]);
            if (j < 3) chk(vsw, 1'b1);
            if (j == 3) chk(ck_act, 1'b1);
            if (j == 5) chk({boot, jig}, 2'h3);
            if (j == 7) chk({boot, jig}, 2'h1);
            plug(ACC_NONE);
            serve(8'h03);
        end
        plug(ACC_AUDIO2);
        m = 3'h1;
        chk(ck_mode, m);
        foreach (pat[k]) begin
            wr(1, pat[k]);
            if (pat[k] != 3'h2) m = pat[k];
            chk(ck_mode, m);
            chk(dda, m == 3'h4);
        end
        chk(ck_act, 1'b0);
        plug(ACC_NONE);
        serve(8'h03);
        plug(ACC_PPD);
        tick(2380);
        chk(vsw, 1'b0);
        tick(200);
        chk(vsw, 1'b1);
        plug(ACC_NONE);
        serve(8'h03);
        plug(ACC_AUDIO1);
        serve(8'h01);
        code <= 5'($random(seed));
        key <= 1'b1;
        tick(1);
        key <= 1'b0;
        serve({code, 3'h4});
        plug(ACC_NONE);
        serve(8'h02);
        bat <= 1'b0;
        plug(ACC_USB_CHARGER);
        chk({chg, jig, u_amc_if.irq_oe}, 3'h0);
        bat <= 1'b1;
        plug(ACC_NONE);
        serve(8'h03);
        plug(ACC_CARKIT);
        wr(1, 3'h0);
        tick(6);
        chk({ck_mode, path}, {3'h0, PATH_USB});
        sup <= 1'b0;
        tick(8);
        chk(ck_mode, 3'h1);
        sup <= 1'b1;
        wr(2, 3'h0);
        plug(ACC_NONE);
        wr(0, 3'h0);
        chk(pend, 1'b0);
        serve(8'h02);
        breq <= 1'b1;
        tick(1);
        breq <= 1'b0;
        tick(2);
        for (i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
        if (busy !== 1'b0) begin
            n_fail++;
            wrap_up();
        end
        tick(8);
        chk({busy, u_amc_if.irq_o}, 2'h0);
        chk(path, PATH_OPEN);
        sup <= 1'b0;
        tick(6);
        plug(ACC_FACT_UART_ON);
        chk(jig, 1'b1);
        sup <= 1'b1;
        tick(6);
        chk(path, PATH_UART);
        wrap_up();
    end
endmodule : accessory_mode_controller_tb_top
`default_nettype wire
